// File: rtl/cwm_waveform_modes.sv
// Purpose: output-mode logic of a complementary waveform generator
// Assumes: single 200 MHz clock; sources, shutdown pin and oscillator
//          arrive asynchronously and are synchronised here
// Notes:   APB slave, one wait state on every access
//
// Summary of operation
// - push-pull alternates pulses between outputs A and B
// - sequencer resets when disabled or shut down
// - first pulse after reset goes to A
// - C and D copy A and B, own polarity
// - mode 010: A active, B C inactive, D modulated
// - mode 011: C active, A D inactive, B modulated
// - direction toggles via lowest mode bit while enabled
// - direction change waits for next input rising edge
// - swap A/C, gate new modulated output through dead band
// - dead band only on modulated output, direction change
// - steering routes input to any output subset
// - steer bit 0 holds override, 1 follows input
// - polarity applies only to steered outputs
// - only steer bits synchronised, override bits direct
// - steering shutdown affects steered outputs only
// - mode 001: steering updates on input rising edge
// - mode 000: steering updates right after write
// - dead-band clock: system clock or fast oscillator
// - oscillator runs in sleep; system clock stops
// - source code selects one of eight inputs
// - polarity set active high; overrides unaffected
// - two 6-bit counters time dead band
module cwm_waveform_modes
	import cwm_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic [7:0]  sources_in,
	input  wire logic        shutdown_n_in,
	input  wire logic        fast_osc_in,
	input  wire logic        sleep_in,
	output logic             output_a_out,
	output logic             output_b_out,
	output logic             output_c_out,
	output logic             output_d_out
);
	import cwm_pkg::*;

	cwm_state_t st;
	cwm_state_t next_st;

	logic        data_s;
	logic        rise;
	logic        tick;
	logic        sd_act;
	logic        is_fb;
	logic        is_steer;
	logic        pp_cur;
	logic        pp_ok;
	logic        modul;
	logic [3:0]  act;
	logic [3:0]  lvl;
	logic        wr;
	logic        rd;
	logic        hit;
	logic [31:0] rdata;

	// ------------------------------------------------------------------
	// decoded conditions
	// ------------------------------------------------------------------
	// the mux reads only the second synchroniser stage
	assign data_s   = st.src_s2[st.src_code];
	assign rise     = data_s & ~st.data_q;
	// system clock halts in sleep, so its ticks stop too
	assign tick     = st.cs ? (st.osc_s2 & ~st.osc_q)
	                        : ~sleep_in;
	assign sd_act   = st.en & (st.sw_sd | (st.ext_sd & ~st.sd_s2));
	assign is_fb    = st.mode[2:1] == MODE_FB_UPPER;
	assign is_steer = (st.mode == MODE_STEER_ASYNC)
	                | (st.mode == MODE_STEER_SYNC);
	// a rising edge in this cycle already belongs to the next side
	assign pp_cur   = rise ? st.pp_next : st.pp_side;
	assign pp_ok    = rise | st.pp_run;
	// the incoming modulated output stays off while dead band runs
	assign modul    = data_s & ~st.busy_r & ~st.busy_f;

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	// write lands only on the edge where pready is seen high
	assign wr = psel_in & penable_in & st.pready & pwrite_in;
	assign rd = psel_in & penable_in & ~st.pready;

	// read mux; unmapped offsets answer zero with pslverr
	always_comb begin
		rdata = 32'h0000_0000;
		hit   = 1'b1;
		case (paddr_in)
			OFS_CONTROL_0: begin
				rdata[POS_ENABLE] = st.en;
				rdata[2:0]        = st.mode;
			end
			OFS_CONTROL_1: rdata[3:0] = st.pol;
			OFS_CLOCK_CTL: rdata[0]   = st.cs;
			OFS_INPUT_SEL: rdata[2:0] = st.src_code;
			OFS_STEER: begin
				rdata[3:0] = st.steer;
				rdata[POS_OVERRIDE +: 4] = st.ovr;
			end
			OFS_DB_RISE:   rdata[5:0] = st.dbr;
			OFS_DB_FALL:   rdata[5:0] = st.dbf;
			OFS_SHUTDOWN: begin
				rdata[0]          = st.sw_sd;
				rdata[POS_EXT_SD] = st.ext_sd;
				rdata[POS_SD_LEVEL +: 4] = st.sd_lvl;
			end
			OFS_STATUS: begin
				rdata[3:0]         = st.outs;
				rdata[POS_DIR]     = st.dir;
				rdata[POS_BUSY]    = st.busy_r | st.busy_f;
				rdata[POS_SD_ACT]  = sd_act;
				rdata[POS_PP_SIDE] = st.pp_next;
			end
			default: hit = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------
	// output levels
	// ------------------------------------------------------------------
	// act holds the active/inactive meaning, before polarity
	always_comb begin
		act = 4'h0;
		case (st.mode)
			MODE_PUSH_PULL: begin
				act[0] = data_s & pp_ok & ~pp_cur;
				act[1] = data_s & pp_ok & pp_cur;
				act[2] = act[0];
				act[3] = act[1];
			end
			MODE_HALF_BRIDGE: begin
				act[0] = data_s;
				act[1] = ~data_s;
				act[2] = act[0];
				act[3] = act[1];
			end
			MODE_FB_FORWARD, MODE_FB_REVERSE: begin
				// static outputs follow the applied direction at once
				act[0] = ~st.dir;
				act[2] = st.dir;
				act[1] = st.dir & modul;
				act[3] = ~st.dir & modul;
			end
			default: act = 4'h0;
		endcase
	end

	// polarity, steering and shutdown merged per output
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (!st.en) begin
				lvl[i] = 1'b0;
			end else if (is_steer) begin
				if (st.steer_act[i]) begin
					// shutdown only reaches steered outputs
					lvl[i] = sd_act ? st.sd_lvl[i]
					       : (st.pol[i] ? data_s : ~data_s);
				end else begin
					lvl[i] = st.ovr[i];
				end
			end else if (sd_act) begin
				lvl[i] = st.sd_lvl[i];
			end else begin
				lvl[i] = st.pol[i] ? act[i] : ~act[i];
			end
		end
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		next_st = st;
		// two-stage synchronisers and edge history
		next_st.src_s1 = sources_in;
		next_st.src_s2 = st.src_s1;
		next_st.sd_s1  = shutdown_n_in;
		next_st.sd_s2  = st.sd_s1;
		next_st.osc_s1 = fast_osc_in;
		next_st.osc_s2 = st.osc_s1;
		next_st.osc_q  = st.osc_s2;
		next_st.data_q = data_s;

		// register writes
		if (wr) begin
			case (paddr_in)
				OFS_CONTROL_0: begin
					next_st.en   = pwdata_in[POS_ENABLE];
					next_st.mode = pwdata_in[2:0];
				end
				OFS_CONTROL_1: next_st.pol      = pwdata_in[3:0];
				OFS_CLOCK_CTL: next_st.cs       = pwdata_in[0];
				OFS_INPUT_SEL: next_st.src_code = pwdata_in[2:0];
				OFS_STEER: begin
					next_st.steer = pwdata_in[3:0];
					next_st.ovr   = pwdata_in[POS_OVERRIDE +: 4];
				end
				OFS_DB_RISE:   next_st.dbr = pwdata_in[5:0];
				OFS_DB_FALL:   next_st.dbf = pwdata_in[5:0];
				OFS_SHUTDOWN: begin
					next_st.sw_sd  = pwdata_in[0];
					next_st.ext_sd = pwdata_in[POS_EXT_SD];
					next_st.sd_lvl = pwdata_in[POS_SD_LEVEL +: 4];
				end
				default: next_st.en = st.en;
			endcase
		end

		// push-pull sequencer
		if (!st.en || sd_act) begin
			next_st.pp_side = 1'b0;
			next_st.pp_next = 1'b0;
			next_st.pp_run  = 1'b0;
		end else if (rise) begin
			next_st.pp_side = st.pp_next;
			next_st.pp_next = ~st.pp_next;
			next_st.pp_run  = 1'b1;
		end

		// full-bridge direction and dead-band counters
		if (!st.en) begin
			next_st.dir    = st.mode[0];
			next_st.busy_r = 1'b0;
			next_st.busy_f = 1'b0;
		end else begin
			// a pending reversal waits for the input's rising edge
			if (is_fb && rise && (st.mode[0] != st.dir)) begin
				next_st.dir = st.mode[0];
				if (st.mode[0]) begin
					next_st.busy_r = st.dbr != RST_DEADBAND;
					next_st.cnt_r  = RST_DEADBAND;
					next_st.busy_f = 1'b0;
				end else begin
					next_st.busy_f = st.dbf != RST_DEADBAND;
					next_st.cnt_f  = RST_DEADBAND;
					next_st.busy_r = 1'b0;
				end
			end else if (tick) begin
				// count dead-band clock periods up to the set value
				if (st.busy_r) begin
					next_st.cnt_r  = st.cnt_r + 6'h01;
					next_st.busy_r = (st.cnt_r + 6'h01) != st.dbr;
				end
				if (st.busy_f) begin
					next_st.cnt_f  = st.cnt_f + 6'h01;
					next_st.busy_f = (st.cnt_f + 6'h01) != st.dbf;
				end
			end
		end

		// steer bits pass through their own register stage
		if (!st.en || st.mode == MODE_STEER_ASYNC) begin
			next_st.steer_act = st.steer;
		end else if (st.mode == MODE_STEER_SYNC && rise) begin
			next_st.steer_act = st.steer;
		end

		next_st.outs = lvl;

		// APB answer: one wait state, then a one-cycle pready
		next_st.pready  = rd;
		next_st.pslverr = rd & ~hit;
		next_st.prdata  = (rd && !pwrite_in) ? rdata : 32'h0000_0000;
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st          <= '0;
			st.pol      <= RST_POLARITY;
			st.src_code <= RST_SOURCE;
			st.dbr      <= RST_DEADBAND;
			st.dbf      <= RST_DEADBAND;
			st.sd_lvl   <= RST_LEVELS;
			st.sd_s1    <= 1'b1;
			st.sd_s2    <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from flip-flops
	assign prdata_out   = st.prdata;
	assign pready_out   = st.pready;
	assign pslverr_out  = st.pslverr;
	assign output_a_out = st.outs[0];
	assign output_b_out = st.outs[1];
	assign output_c_out = st.outs[2];
	assign output_d_out = st.outs[3];

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);

	property p_pp_exclusive;
		(st.mode == MODE_PUSH_PULL) && st.en && !sd_act && (st.pol[1:0] == 2'h3)
		|=> !(st.outs[0] && st.outs[1]);
	endproperty
	a_pp_exclusive: assert property (p_pp_exclusive)
		else $error("push-pull drove A and B together");

	property p_pp_reset;
		!st.en |=> !st.pp_next && !st.pp_run;
	endproperty
	a_pp_reset: assert property (p_pp_reset)
		else $error("sequencer not reset while disabled");

	property p_pp_first_a;
		(st.mode == MODE_PUSH_PULL) && st.en && !sd_act && rise && !st.pp_run
		|=> (st.outs[0] == $past(st.pol[0])) && (st.outs[1] == !$past(st.pol[1]));
	endproperty
	a_pp_first_a: assert property (p_pp_first_a)
		else $error("first push-pull pulse not on A");

	property p_pp_copy;
		(st.mode == MODE_PUSH_PULL) && st.en && !sd_act
		|=> st.outs[2] == (st.outs[0] ^ $past(st.pol[0]) ^ $past(st.pol[2]));
	endproperty
	a_pp_copy: assert property (p_pp_copy)
		else $error("C does not copy A");

	property p_fb_forward;
		is_fb && st.en && !sd_act && !st.dir
		|=> (st.outs[0] == $past(st.pol[0])) && (st.outs[1] == !$past(st.pol[1]))
		    && (st.outs[2] == !$past(st.pol[2]));
	endproperty
	a_fb_forward: assert property (p_fb_forward)
		else $error("forward static outputs wrong");

	property p_dir_hold;
		is_fb && st.en && !rise |=> st.dir == $past(st.dir);
	endproperty
	a_dir_hold: assert property (p_dir_hold)
		else $error("direction changed without a rising edge");

	property p_db_gate;
		is_fb && st.en && !sd_act && st.dir && st.busy_r
		|=> st.outs[1] == !$past(st.pol[1]);
	endproperty
	a_db_gate: assert property (p_db_gate)
		else $error("B modulated during dead band");

	property p_override;
		is_steer && st.en && !st.steer_act[0] |=> st.outs[0] == $past(st.ovr[0]);
	endproperty
	a_override: assert property (p_override)
		else $error("unsteered output not at override level");

	property p_sync_hold;
		(st.mode == MODE_STEER_SYNC) && st.en && !rise
		|=> st.steer_act == $past(st.steer_act);
	endproperty
	a_sync_hold: assert property (p_sync_hold)
		else $error("synchronous steering changed off an edge");

	property p_async_take;
		(st.mode == MODE_STEER_ASYNC) && st.en |=> st.steer_act == $past(st.steer);
	endproperty
	a_async_take: assert property (p_async_take)
		else $error("asynchronous steering not applied");

	property p_sleep_stall;
		!st.cs && sleep_in && st.busy_r && !rise |=> st.cnt_r == $past(st.cnt_r);
	endproperty
	a_sleep_stall: assert property (p_sleep_stall)
		else $error("dead band counted in sleep on system clock");

	property p_count_step;
		st.en && st.busy_f && tick && !rise
		|=> st.cnt_f == $past(st.cnt_f) + 6'h01;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("dead-band counter did not step");

	c_pp_to_b:  cover property (rise && st.pp_run && st.pp_next);
	c_reverse:  cover property (is_fb && rise && st.mode[0] && !st.dir);
	c_sync_upd: cover property ((st.mode == MODE_STEER_SYNC) && rise);
	c_shutdown: cover property (sd_act && is_steer);
endmodule

// File: rtl/cwm_pkg.sv
// Purpose: shared constants and types for the complementary waveform modes
// Assumes: APB slave with 32-bit data, 8-bit byte address, one aligned word
//          per register
// Notes:   bits above each register's documented width read as zero
package cwm_pkg;
	// ------------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL_0  = 8'h00; // waveform_control_0
	localparam logic [7:0] OFS_CONTROL_1  = 8'h04; // waveform_control_1
	localparam logic [7:0] OFS_CLOCK_CTL  = 8'h08; // deadband_clock_control
	localparam logic [7:0] OFS_INPUT_SEL  = 8'h0C; // input_source_select
	localparam logic [7:0] OFS_STEER      = 8'h10; // steer and override bits
	localparam logic [7:0] OFS_DB_RISE    = 8'h14; // rising/reverse dead band
	localparam logic [7:0] OFS_DB_FALL    = 8'h18; // falling/forward dead band
	localparam logic [7:0] OFS_SHUTDOWN   = 8'h1C; // shutdown control
	localparam logic [7:0] OFS_STATUS     = 8'h20; // read-only live state
	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int POS_ENABLE   = 7;  // control_0 enable bit
	localparam int POS_OVERRIDE = 4;  // steer reg: override levels [7:4]
	localparam int POS_EXT_SD   = 1;  // shutdown reg: pin shutdown enable
	localparam int POS_SD_LEVEL = 4;  // shutdown reg: levels [7:4]
	localparam int POS_DIR      = 4;  // status: full-bridge direction
	localparam int POS_BUSY     = 5;  // status: dead band running
	localparam int POS_SD_ACT   = 6;  // status: shutdown active
	localparam int POS_PP_SIDE  = 7;  // status: push-pull next side
	// ------------------------------------------------------------------
	// mode codes
	// ------------------------------------------------------------------
	localparam logic [2:0] MODE_STEER_ASYNC = 3'h0;
	localparam logic [2:0] MODE_STEER_SYNC  = 3'h1;
	localparam logic [2:0] MODE_FB_FORWARD  = 3'h2;
	localparam logic [2:0] MODE_FB_REVERSE  = 3'h3;
	localparam logic [2:0] MODE_HALF_BRIDGE = 3'h4; // chosen code
	localparam logic [2:0] MODE_PUSH_PULL   = 3'h5; // chosen code
	localparam logic [1:0] MODE_FB_UPPER    = 2'h1; // mode[2:1] of full bridge
	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [3:0] RST_POLARITY = 4'hF; // active-high outputs
	localparam logic [5:0] RST_DEADBAND = 6'h00;
	localparam logic [2:0] RST_SOURCE   = 3'h0;
	localparam logic [3:0] RST_LEVELS   = 4'h0;
	// ------------------------------------------------------------------
	// all module state in one packed word
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  src_s1;    // source synchroniser, stage 1
		logic [7:0]  src_s2;    // source synchroniser, stage 2
		logic        sd_s1;
		logic        sd_s2;
		logic        osc_s1;
		logic        osc_s2;
		logic        osc_q;     // previous osc sample, edge detect
		logic        data_q;    // previous data sample, edge detect
		logic        en;
		logic [2:0]  mode;
		logic [3:0]  pol;       // invert_out_n: 1 = active high
		logic        cs;        // 1 = internal_fast_osc
		logic [2:0]  src_code;  // input_source_code
		logic [3:0]  steer;     // steer_select_n as written
		logic [3:0]  ovr;       // override_level_n
		logic [5:0]  dbr;
		logic [5:0]  dbf;
		logic        sw_sd;
		logic        ext_sd;
		logic [3:0]  sd_lvl;
		logic [3:0]  steer_act; // steer bits in force
		logic        dir;       // 0 forward, 1 reverse
		logic        busy_r;
		logic        busy_f;
		logic [5:0]  cnt_r;
		logic [5:0]  cnt_f;
		logic        pp_side;   // side of pulse in progress, 0 = A
		logic        pp_next;   // side of next pulse
		logic        pp_run;    // a pulse has advanced the sequencer
		logic [3:0]  outs;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} cwm_state_t;
endpackage

// File: test/cwm_bridge_model.sv
// Purpose: bridge driver model sitting on the four waveform outputs
// Assumes: A/B drive one half-bridge leg, C/D the other, active high
// Notes:   counts A and B turn-on events; flags a leg with both switches on
module cwm_bridge_model (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic [3:0] gate_in,
	output logic      [7:0] ons_a_out,
	output logic      [7:0] ons_b_out,
	output logic            shoot_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] last;
	// live overlap flag, not sticky, so steering tests may overlap freely
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			last <= 4'h0;
			ons_a_out <= 8'h00;
			ons_b_out <= 8'h00;
			shoot_out <= 1'h0;
		end else begin
			last <= gate_in;
			if (gate_in[0] && !last[0]) begin
				ons_a_out <= ons_a_out + 8'h01;
			end
			if (gate_in[1] && !last[1]) begin
				ons_b_out <= ons_b_out + 8'h01;
			end
			shoot_out <= (gate_in[0] & gate_in[1]) | (gate_in[2] & gate_in[3]);
		end
	end
endmodule

// File: test/tb_top.sv
// Purpose: self-checking bench for the waveform modes block
// Assumes: APB master, one transfer at a time
// Notes:   source data comes from a fixed-seed xorshift generator
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import cwm_pkg::*;
	// --------
	// signals
	// --------
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic        psel = 1'h0;
	logic        pen = 1'h0;
	logic        pwr = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [7:0]  src = 8'h00;
	logic        osc = 1'h0;
	logic        sleep = 1'h0;
	logic        sd_n = 1'h1;
	logic [31:0] seed = 32'h09EBECF3;
	int          sel = 0;
	int          miscompares = 0;
	int          total_checks = 0;
	wire [31:0]  prdata;
	wire         pready;
	wire         pslverr;
	wire [3:0]   outs;
	wire [7:0]   ons_a;
	wire [7:0]   ons_b;
	wire         shoot;
	always #2.5 clk = ~clk;
	// oscillator only matters once the dead-band clock is switched to it
	always @(posedge clk) osc <= ~osc;
	cwm_waveform_modes dut_u (
		.sys_clk_in   (clk),
		.sys_rst_in   (rst),
		.psel_in      (psel),
		.penable_in   (pen),
		.pwrite_in    (pwr),
		.paddr_in     (paddr),
		.pwdata_in    (pwdata),
		.prdata_out   (prdata),
		.pready_out   (pready),
		.pslverr_out  (pslverr),
		.sources_in   (src),
		.shutdown_n_in(sd_n),
		.fast_osc_in  (osc),
		.sleep_in     (sleep),
		.output_a_out (outs[0]),
		.output_b_out (outs[1]),
		.output_c_out (outs[2]),
		.output_d_out (outs[3])
	);
	cwm_bridge_model bridge_u (
		.clk_in   (clk),
		.rst_in   (rst),
		.gate_in  (outs),
		.ons_a_out(ons_a),
		.ons_b_out(ons_b),
		.shoot_out(shoot)
	);
	// --------
	// helpers
	// --------
	task automatic stop_test();
		if (miscompares == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// steered outputs follow the data with polarity, others hold override
	function automatic logic [3:0] exp_steer(input logic [3:0] st,
		input logic [3:0] ov, input logic [3:0] pl, input logic v);
		return (st & ({4{v}} ~^ pl)) | (~st & ov);
	endfunction
	task automatic apb(input logic wr_en, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		pwr <= wr_en;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		n = 0;
		// pready is taken at the rising edge that ends the transfer
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
		if (n >= 16) begin
			miscompares++;
			stop_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'h1, a, d, r, e);
		chk_reg({31'h0, e}, 32'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'h0, a, 32'h0, r, e);
		chk_reg(r, exp);
	endtask
	// other source bits are scrambled so a wrong selection shows up
	task automatic set_src(input logic v);
		logic [7:0] r;
		r = 8'(rnd() >> 8);
		r[sel] = v;
		@(posedge clk);
		src <= r;
		repeat (4) @(posedge clk);
	endtask
	task automatic look(input logic [3:0] exp);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk_reg({28'h0, outs}, {28'h0, exp});
	endtask
	// direction change: nothing moves before the rise, then a dead band;
	// tp is cycles per tick, sl ticks lost to sleep on the system clock
	task automatic flip(input logic [2:0] m, input logic [3:0] old,
		input logic [3:0] fin, input int mb, input int db, input int tp,
		input int sl);
		int n;
		int lo;
		// two sync stages, direction register, output register
		lo = db * tp + sl + 3;
		set_src(1'h0);
		wr(OFS_CONTROL_0, 32'h80 | 32'(m));
		look(old);
		@(posedge clk);
		src[sel] <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			// sleep only while the dead band is counting
			sleep <= n >= 2 && n < sl + 2;
			@(negedge clk);
			n++;
			chk_reg({31'h0, shoot}, 32'h0);
		end while (outs[mb] !== 1'h1 && n < 80);
		chk_reg({31'h0, n >= lo && n <= lo + 1}, 32'h1);
		chk_reg({28'h0, outs}, {28'h0, fin});
		if (n >= 80) begin
			stop_test();
		end
	endtask
	// --------
	// scenarios
	// --------
	initial begin
		logic [31:0] r;
		logic        e;
		logic [7:0]  a0;
		logic [7:0]  b0;
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		rd(OFS_CONTROL_1, 32'(RST_POLARITY));
		rd(OFS_CONTROL_0, 32'h0);
		apb(1'h0, 8'h40, 32'h0, r, e);
		chk_reg({31'h0, e}, 32'h1);
		wr(OFS_CLOCK_CTL, 32'h1);
		rd(OFS_CLOCK_CTL, 32'h1);
		wr(OFS_CLOCK_CTL, 32'h0);
		// each input code routes its own source to a steered output A
		for (int i = 0; i < 8; i++) begin
			wr(OFS_CONTROL_0, 32'h0);
			wr(OFS_INPUT_SEL, 32'(i));
			sel = i;
			wr(OFS_STEER, 32'h1);
			wr(OFS_CONTROL_0, 32'h80);
			set_src(1'h1);
			look(4'h1);
			set_src(1'h0);
			look(4'h0);
		end
		// random steering, override and polarity sets, rewritten live
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			wr(OFS_CONTROL_1, 32'(r[11:8]));
			wr(OFS_STEER, 32'(r[7:0]));
			set_src(r[12]);
			look(exp_steer(r[3:0], r[7:4], r[11:8], r[12]));
		end
		wr(OFS_CONTROL_0, 32'h0);
		wr(OFS_CONTROL_1, 32'hF);
		wr(OFS_STEER, 32'h1);
		wr(OFS_CONTROL_0, 32'h81);
		set_src(1'h0);
		set_src(1'h1);
		look(4'h1);
		wr(OFS_STEER, 32'h42);
		look(4'h5);
		set_src(1'h0);
		look(4'h4);
		set_src(1'h1);
		look(4'h6);
		// pin shutdown forces steered B low, override C stays high
		wr(OFS_SHUTDOWN, 32'h2);
		@(posedge clk);
		sd_n <= 1'h0;
		repeat (2) @(posedge clk);
		look(4'h4);
		@(posedge clk);
		sd_n <= 1'h1;
		wr(OFS_SHUTDOWN, 32'h0);
		look(4'h6);
		wr(OFS_CONTROL_0, 32'h0);
		wr(OFS_DB_RISE, 32'h5);
		wr(OFS_DB_FALL, 32'h3);
		wr(OFS_CONTROL_0, 32'h82);
		set_src(1'h0);
		look(4'h1);
		set_src(1'h1);
		look(4'h9);
		flip(MODE_FB_REVERSE, 4'h1, 4'h6, 1, 5, 1, 3);
		set_src(1'h0);
		look(4'h4);
		wr(OFS_CLOCK_CTL, 32'h1);
		flip(MODE_FB_FORWARD, 4'h4, 4'h9, 3, 3, 2, 0);
		wr(OFS_CONTROL_0, 32'h0);
		wr(OFS_CONTROL_0, 32'h80 | 32'(MODE_PUSH_PULL));
		set_src(1'h0);
		a0 = ons_a;
		b0 = ons_b;
		// pulses alternate; a shutdown before the fourth restarts at A
		for (int i = 0; i < 5; i++) begin
			if (i == 3) begin
				wr(OFS_SHUTDOWN, 32'h1);
				wr(OFS_SHUTDOWN, 32'h0);
			end
			set_src(1'h1);
			look((i == 1 || i == 4) ? 4'hA : 4'h5);
			set_src(1'h0);
			look(4'h0);
		end
		wr(OFS_CONTROL_0, 32'h0);
		wr(OFS_CONTROL_0, 32'h80 | 32'(MODE_PUSH_PULL));
		set_src(1'h1);
		look(4'h5);
		chk_reg(32'(8'(ons_a - a0)), 32'h4);
		chk_reg(32'(8'(ons_b - b0)), 32'h2);
		stop_test();
	end
endmodule
